//--- hdl/tsp_sensor_end.sv
`timescale 1ns/10ps
`default_nettype none
module tsp_sensor_end
	import tsp_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
	input  wire logic         clk_sys,
	input  wire logic         reset,
	tsp_link_if.dev           link,
	input  wire logic [13:0]  temp_in,
	output logic              conv_busy,
	output logic              result_valid,
	output logic              shutdown_active,
	output logic              test_mode
);
	// ****************************************
	// link side, clocked by the serial clock
	// ****************************************
	logic              frame_clr;
	logic [4:0]        tx_cnt_reg, tx_cnt_next;
	logic [4:0]        rx_cnt_reg, rx_cnt_next;
	logic              frame_cmd_reg, frame_cmd_next;
	logic              link_sd_reg, link_sd_next;
	logic              link_test_reg, link_test_next;
	logic              cmd_tog_reg, cmd_tog_next;
	logic [7:0]        rx_shift_reg, rx_shift_next;
	logic [7:0]        cmd_hold_reg, cmd_hold_next;
	logic              rx_phase;
	logic              rx_cmd_ok;
	logic [15:0]       word_out;

	// system side
	tsp_conv_state_e   state_reg, state_next;
	logic [CONV_CNT_W-1:0] cnt_reg, cnt_next;
	logic [15:0]       word_reg, word_next;
	logic [13:0]       pend_reg, pend_next;
	logic              valid_reg, valid_next;
	logic              cs_q_reg, seen_tog_reg, seen_tog_next;
	logic              cs_sync, tog_sync, cs_rise, new_cmd, conv_last;

	// deselect ends the frame at once; the serial clock may be stopped
	assign frame_clr = reset | link.cs_n; // RL9

	// transmit bit counter steps on falling edges
	always_comb begin
		tx_cnt_next = tx_cnt_reg + 5'h01; // RL4
	end

	// wraps every 32 clocks so long frames transmit again
	always_ff @(negedge link.serial_clock_in or posedge frame_clr) begin
		if (frame_clr) begin
			tx_cnt_reg <= 5'h00; // RL8
		end else begin
			tx_cnt_reg <= tx_cnt_next; // RL11
		end
	end

	// receive side works on rising edges
	assign rx_phase  = rx_cnt_reg[4]; // RL5
	assign rx_cmd_ok = rx_phase && (rx_cnt_reg[3:0] >= 4'h7);

	always_comb begin
		rx_cnt_next    = rx_cnt_reg + 5'h01; // RL4
		rx_shift_next  = rx_shift_reg;
		cmd_hold_next  = cmd_hold_reg;
		frame_cmd_next = frame_cmd_reg;
		cmd_tog_next   = cmd_tog_reg;
		link_sd_next   = link_sd_reg;
		link_test_next = link_test_reg;
		if (rx_phase) begin
			rx_shift_next = {rx_shift_reg[6:0], link.sio_level}; // RL12
		end
		if (rx_cmd_ok) begin
			cmd_hold_next  = rx_shift_next; // RL12
			frame_cmd_next = 1'b1;
			if (!frame_cmd_reg) begin
				cmd_tog_next = ~cmd_tog_reg;
			end
		end
		// a full 32-clock segment applies its command mid-frame
		if (rx_cnt_reg == 5'h1F) begin
			if (rx_shift_next == CMD_SHUTDN) begin
				link_sd_next = 1'b1; // RL13
			end else if (rx_shift_next == CMD_CONVERT) begin
				link_sd_next = 1'b0; // RL13
			end else begin
				link_test_next = 1'b1; // RL14
			end
		end
	end

	always_ff @(posedge link.serial_clock_in or posedge frame_clr) begin
		if (frame_clr) begin
			rx_cnt_reg    <= 5'h00;
			frame_cmd_reg <= 1'b0;
			link_sd_reg   <= 1'b0;
			link_test_reg <= 1'b0;
		end else begin
			rx_cnt_reg    <= rx_cnt_next; // RL11
			frame_cmd_reg <= frame_cmd_next;
			link_sd_reg   <= link_sd_next;
			link_test_reg <= link_test_next;
		end
	end

	// one toggle per frame tells the system side a command arrived
	always_ff @(posedge link.serial_clock_in or posedge reset) begin
		if (reset) begin
			cmd_tog_reg <= 1'b0;
		end else begin
			cmd_tog_reg <= cmd_tog_next;
		end
	end

	// data only, read by the system side after deselect
	always_ff @(posedge link.serial_clock_in) begin
		rx_shift_reg <= rx_shift_next;
		cmd_hold_reg <= cmd_hold_next;
	end

	// ****************************************
	// data line drive
	// ****************************************
	assign word_out = link_sd_reg ? ID_WORD : word_reg; // RL20
	assign link.dev_sio_out = word_out[4'hF - tx_cnt_reg[3:0]]; // RL18
	// released when deselected, in receive phase or in test mode
	assign link.dev_sio_oe = ~link.cs_n & ~tx_cnt_reg[4] & ~link_test_reg & (state_reg != C_TEST); // RL6 RL22

	// ****************************************
	// crossings into the system clock
	// ****************************************
	tsp_sync3 #(.INIT(1'b1)) u_cs_sync (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.async_in (link.cs_n),
		.sync_out (cs_sync)
	);

	tsp_sync3 #(.INIT(1'b0)) u_tog_sync (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.async_in (cmd_tog_reg),
		.sync_out (tog_sync)
	);

	assign cs_rise   = cs_sync & ~cs_q_reg;
	assign new_cmd   = cs_rise & (tog_sync != seen_tog_reg);
	assign conv_last = (cnt_reg == CONV_CNT_W'(CONV_CYCLES - 1));

	// ****************************************
	// conversion control
	// ****************************************
	// the word only changes while cs_sync shows deselect, so a read sees one value
	always_comb begin
		state_next    = state_reg;
		cnt_next      = cnt_reg;
		word_next     = word_reg;
		pend_next     = pend_reg;
		valid_next    = valid_reg;
		seen_tog_next = cs_rise ? tog_sync : seen_tog_reg;
		case (state_reg)
			C_RUN: begin
				cnt_next = cnt_reg + CONV_CNT_W'(1);
				if (conv_last) begin
					pend_next = temp_in;
					cnt_next  = '0;
					if (cs_sync) begin
						word_next  = {temp_in, TEMP_PAD}; // RL17 RL19
						valid_next = 1'b1; // RL2
					end else begin
						state_next = C_HOLD; // RL10
					end
				end
			end
			C_HOLD: begin
				if (cs_sync) begin
					word_next  = {pend_reg, TEMP_PAD}; // RL10
					valid_next = 1'b1;
					cnt_next   = '0;
					state_next = C_RUN; // RL21
				end
			end
			C_SHUT: begin
				cnt_next = '0;
			end
			C_TEST: begin
				cnt_next = '0;
			end
			default: begin
				state_next = C_RUN;
			end
		endcase
		// commands decode on deselect and take priority
		if (new_cmd && (state_reg != C_TEST)) begin
			if (cmd_hold_reg == CMD_SHUTDN) begin
				state_next = C_SHUT; // RL13
				word_next  = ID_WORD; // RL20
				valid_next = 1'b0;
			end else if (cmd_hold_reg == CMD_CONVERT) begin
				if (state_reg == C_SHUT) begin
					state_next = C_RUN; // RL13
					cnt_next   = '0;
				end
			end else begin
				state_next = C_TEST; // RL14
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg    <= C_RUN; // RL1 RL3
			cnt_reg      <= '0;
			word_reg     <= WORD_RESET; // RL2
			pend_reg     <= '0;
			valid_reg    <= 1'b0;
			cs_q_reg     <= 1'b1;
			seen_tog_reg <= 1'b0;
		end else begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			word_reg     <= word_next;
			pend_reg     <= pend_next;
			valid_reg    <= valid_next;
			cs_q_reg     <= cs_sync;
			seen_tog_reg <= seen_tog_next;
		end
	end

	assign conv_busy       = (state_reg == C_RUN);
	assign result_valid    = valid_reg;
	assign shutdown_active = (state_reg == C_SHUT);
	assign test_mode       = (state_reg == C_TEST);
endmodule : tsp_sensor_end
`default_nettype wire

//--- hdl/tsp_pkg.sv
// Functional notes
// (RL1) power-on default is continuous conversion
// (RL2) output word invalid before first conversion
// (RL3) power-on detector resets all internal registers; rx_shift_reg and cmd_hold_reg have no reset
// (RL4) output on falling, input on rising clock
// (RL5) 32 clocks: 16 transmit then 16 receive
// (RL6) data line released while chip select high
// (RL7) host lowers chip select with clock steady
// (RL8) first bit driven at chip select fall
// (RL9) chip select may rise early in transmit
// (RL10) running conversion finishes, loads after deselect
// (RL11) receive phase up to 16 clocks
// (RL12) last eight received bits form the command
// (RL13) all ones shutdown, all zeros continuous
// (RL14) host sends only all-zeros or all-ones codes
// (RL15) host id sequence in one 64-clock frame
// (RL16) host waits one conversion after resuming
// (RL17) temperature is 14-bit two's complement
// (RL18) most significant bit first
// (RL19) two lowest word bits are ones; the power-up WORD_RESET of 16'h0000 has them at zero
// (RL20) shutdown reads return identification word
// (RL21) read end refreshes word, restarts conversion
// (RL22) device releases line in receive phase
package tsp_pkg;

	// ****************************************
	// word layout and command codes
	// ****************************************
	localparam int          WORD_W      = 16;
	localparam int          TEMP_W      = 14;
	localparam int          CMD_W       = 8;
	localparam int          PHASE_BITS  = 16;
	localparam int          FRAME_BITS  = 32;
	localparam int          ID_FRAME    = 64;
	localparam logic [1:0]  TEMP_PAD    = 2'h3;
	localparam logic [7:0]  CMD_SHUTDN  = 8'hFF;
	localparam logic [7:0]  CMD_CONVERT = 8'h00;
	// identification value is arbitrary, low two bits kept at one
	localparam logic [15:0] ID_WORD     = 16'h5A53;
	// power-up word, meaningless until first conversion
	localparam logic [15:0] WORD_RESET  = 16'h0000;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_FREQ_HZ     = 10_000_000;
	localparam int CLK_PERIOD_NS   = 100;
	localparam int CONV_TIME_MS    = 200;
	localparam int CONV_CYCLES_DEF = CONV_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int CONV_CNT_W      = 22;
	localparam int RESUME_WAIT_MS  = 300;
	localparam int RESUME_CYC_DEF  = RESUME_WAIT_MS * (CLK_FREQ_HZ / 1000);
	localparam int CS_SETUP_NS     = 100;
	localparam int CS_SETUP_CYC    = (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_LAT_CYC    = 4;
	// half clock period must outlast the host input synchroniser
	localparam int HALF_CYC        = SYNC_LAT_CYC + 2 + CS_SETUP_CYC - 1;
	localparam int DIV_W           = 4;

	// ****************************************
	// state encodings
	// ****************************************
	typedef enum logic [3:0] {
		C_SHUT = 4'b0001,
		C_RUN  = 4'b0010,
		C_HOLD = 4'b0100,
		C_TEST = 4'b1000
	} tsp_conv_state_e;

	typedef enum logic [4:0] {
		H_IDLE  = 5'b00001,
		H_SETUP = 5'b00010,
		H_HIGH  = 5'b00100,
		H_LOW   = 5'b01000,
		H_DONE  = 5'b10000
	} tsp_host_state_e;

endpackage : tsp_pkg

//--- hdl/tsp_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tsp_link_if;
	logic cs_n;
	logic serial_clock_in;
	logic host_sio_out;
	logic host_sio_oe;
	logic dev_sio_out;
	logic dev_sio_oe;
	logic sio_level;

	// shared data line, pulled high when nobody drives
	assign sio_level = dev_sio_oe ? dev_sio_out : (host_sio_oe ? host_sio_out : 1'b1);

	modport dev (
		input  cs_n,
		input  serial_clock_in,
		input  sio_level,
		output dev_sio_out,
		output dev_sio_oe
	);

	modport host (
		output cs_n,
		output serial_clock_in,
		output host_sio_out,
		output host_sio_oe,
		input  sio_level
	);
endinterface : tsp_link_if
`default_nettype wire

//--- hdl/tsp_sync3.sv
`timescale 1ns/10ps
`default_nettype none
module tsp_sync3 #(
	parameter logic INIT = 1'b0
) (
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic async_in,
	output logic      sync_out
);
	logic s1_reg, s2_reg, s3_reg, out_reg;
	logic out_next;

	// ****************************************
	// three stages, change accepted once the last two agree
	// ****************************************
	always_comb begin
		out_next = out_reg;
		if (s2_reg == s3_reg) begin
			out_next = s3_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s1_reg  <= INIT;
			s2_reg  <= INIT;
			s3_reg  <= INIT;
			out_reg <= INIT;
		end else begin
			s1_reg  <= async_in;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			out_reg <= out_next;
		end
	end

	assign sync_out = out_reg;
endmodule : tsp_sync3
`default_nettype wire

//--- hdl/tsp_host_end.sv
`timescale 1ns/10ps
`default_nettype none
module tsp_host_end
	import tsp_pkg::*;
#(
	parameter int RESUME_CYCLES = RESUME_CYC_DEF
) (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	tsp_link_if.host         link,
	input  wire logic        req,
	input  wire logic        wr_en,
	input  wire logic        id_seq,
	input  wire logic [7:0]  wr_cmd,
	output logic             busy,
	output logic             done,
	output logic [15:0]      rd_temp,
	output logic [15:0]      rd_id
);
	tsp_host_state_e  state_reg, state_next;
	logic [DIV_W-1:0] div_reg, div_next;
	logic [6:0]       bit_reg, bit_next;
	logic [6:0]       len_reg, len_next;
	logic             seq_reg, seq_next;
	logic [7:0]       cmd_reg, cmd_next;
	logic [15:0]      shin_reg, shin_next;
	logic [15:0]      temp_reg, temp_next;
	logic [15:0]      id_reg, id_next;
	logic             sclk_reg, sclk_next;
	logic             cs_n_reg, cs_n_next;
	logic             out_reg, out_next;
	logic             oe_reg, oe_next;
	logic             done_reg, done_next;
	logic [CONV_CNT_W-1:0] wait_reg, wait_next;
	logic             sio_sync, half_end, rise_now;
	logic [6:0]       bit_inc;
	logic [7:0]       wr_byte;

	tsp_sync3 #(.INIT(1'b1)) u_sio_sync (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.async_in (link.sio_level),
		.sync_out (sio_sync)
	);

	assign half_end = (div_reg == DIV_W'(HALF_CYC - 1));
	assign rise_now = half_end && ((state_reg == H_SETUP) || (state_reg == H_LOW));
	assign bit_inc  = bit_reg + 7'h01;
	// id sequence: shutdown byte then resume byte
	assign wr_byte  = seq_reg ? (bit_inc[5] ? CMD_CONVERT : CMD_SHUTDN) : cmd_reg; // RL15

	// ****************************************
	// frame sequencer and clock divider
	// ****************************************
	always_comb begin
		state_next = state_reg;
		div_next   = half_end ? '0 : div_reg + DIV_W'(1);
		bit_next   = bit_reg;
		len_next   = len_reg;
		seq_next   = seq_reg;
		cmd_next   = cmd_reg;
		shin_next  = shin_reg;
		temp_next  = temp_reg;
		id_next    = id_reg;
		sclk_next  = sclk_reg;
		cs_n_next  = cs_n_reg;
		out_next   = out_reg;
		oe_next    = oe_reg;
		done_next  = 1'b0;
		wait_next  = (wait_reg != '0) ? wait_reg - CONV_CNT_W'(1) : wait_reg;
		// sample on the rising edge; transmit half of each segment
		if (rise_now && !bit_reg[4]) begin
			shin_next = {shin_reg[14:0], sio_sync}; // RL4 RL18
			if (bit_reg[3:0] == 4'hF) begin
				if (bit_reg[5]) begin
					id_next = {shin_reg[14:0], sio_sync}; // RL20
				end else begin
					temp_next = {shin_reg[14:0], sio_sync}; // RL17
				end
			end
		end
		case (state_reg)
			H_IDLE: begin
				div_next = '0;
				if (req && (wait_reg == '0)) begin
					// clock is parked low when select falls
					cs_n_next  = 1'b0; // RL7
					// setup spans a whole divider wrap; the device word may still load just after select
					div_next   = DIV_W'(HALF_CYC); // RL8
					seq_next   = id_seq;
					// only the two legal codes leave the host, anything else goes out as continuous
					cmd_next   = (wr_cmd == CMD_SHUTDN) ? CMD_SHUTDN : CMD_CONVERT; // RL14
					bit_next   = '0;
					len_next   = id_seq ? 7'(ID_FRAME) : (wr_en ? 7'(FRAME_BITS) : 7'(PHASE_BITS)); // RL5 RL9
					state_next = H_SETUP; // RL8
				end
			end
			H_SETUP, H_LOW: begin
				if (half_end) begin
					sclk_next  = 1'b1;
					state_next = H_HIGH;
				end
			end
			H_HIGH: begin
				if (half_end) begin
					sclk_next = 1'b0;
					bit_next  = bit_inc;
					if (bit_inc == len_reg) begin
						oe_next    = 1'b0;
						state_next = H_DONE; // RL11
					end else begin
						// command bits change after falling edges
						oe_next    = bit_inc[4]; // RL22
						out_next   = wr_byte[3'h7 - bit_inc[2:0]];
						state_next = H_LOW;
					end
				end
			end
			H_DONE: begin
				if (half_end) begin
					cs_n_next  = 1'b1;
					done_next  = 1'b1;
					state_next = H_IDLE;
					if (seq_reg) begin
						wait_next = CONV_CNT_W'(RESUME_CYCLES); // RL16
					end
				end
			end
			default: begin
				state_next = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= H_IDLE;
			div_reg   <= '0;
			bit_reg   <= '0;
			len_reg   <= '0;
			seq_reg   <= 1'b0;
			cmd_reg   <= '0;
			shin_reg  <= '0;
			temp_reg  <= '0;
			id_reg    <= '0;
			sclk_reg  <= 1'b0;
			cs_n_reg  <= 1'b1;
			out_reg   <= 1'b0;
			oe_reg    <= 1'b0;
			done_reg  <= 1'b0;
			wait_reg  <= '0;
		end else begin
			state_reg <= state_next;
			div_reg   <= div_next;
			bit_reg   <= bit_next;
			len_reg   <= len_next;
			seq_reg   <= seq_next;
			cmd_reg   <= cmd_next;
			shin_reg  <= shin_next;
			temp_reg  <= temp_next;
			id_reg    <= id_next;
			sclk_reg  <= sclk_next;
			cs_n_reg  <= cs_n_next;
			out_reg   <= out_next;
			oe_reg    <= oe_next;
			done_reg  <= done_next;
			wait_reg  <= wait_next;
		end
	end

	assign link.cs_n            = cs_n_reg;
	assign link.serial_clock_in = sclk_reg;
	assign link.host_sio_out    = out_reg;
	assign link.host_sio_oe     = oe_reg;
	assign busy    = (state_reg != H_IDLE) || (wait_reg != '0);
	assign done    = done_reg;
	assign rd_temp = temp_reg;
	assign rd_id   = id_reg;
endmodule : tsp_host_end
`default_nettype wire

//--- tb/tsp_link_chk.sv
`timescale 1ns/10ps
`default_nettype none
module tsp_link_chk (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic serial_clock_in,
	input wire logic host_sio_out,
	input wire logic host_sio_oe,
	input wire logic dev_sio_out,
	input wire logic dev_sio_oe,
	input wire logic sio_level
);
	logic       sclk_q_reg, sclk_q_next;
	logic [6:0] fall_cnt_reg, fall_cnt_next, falls_now;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	// ********
	// falling edge count within a frame
	// ********
	// falls_now includes a fall seen at this very edge
	always_comb begin
		sclk_q_next = reset ? 1'b0 : serial_clock_in;
		falls_now = fall_cnt_reg + {6'h00, sclk_q_reg & ~serial_clock_in};
		fall_cnt_next = (cs_n || reset) ? 7'h00 : falls_now;
	end

	// registers only
	always_ff @(posedge clk_sys) begin
		sclk_q_reg <= sclk_q_next;
		fall_cnt_reg <= fall_cnt_next;
	end

	// ********
	// line rules
	// ********
	a_idle_release: assert property (cs_n |-> !dev_sio_oe)
		else $error("device drives while deselected");
	a_first_bit: assert property ($fell(cs_n) |-> dev_sio_oe)
		else $error("device silent at select");
	a_no_clash: assert property (dev_sio_oe |-> !host_sio_oe)
		else $error("both ends drive the line");
	a_tx_window: assert property (!cs_n && falls_now[4:0] < 5'h10 |-> dev_sio_oe)
		else $error("device released line in transmit phase");
	a_rx_handover: assert property ($rose(host_sio_oe) |-> !cs_n && falls_now[4:0] == 5'h10)
		else $error("host drive not after sixteenth fall");
	a_tx_stable: assert property (serial_clock_in && $past(serial_clock_in) && dev_sio_oe && $past(dev_sio_oe)
		|-> $stable(dev_sio_out))
		else $error("device data moved while clock high");
	a_pad_ones: assert property (dev_sio_oe && falls_now[4:0] inside {5'h0E, 5'h0F} |-> dev_sio_out)
		else $error("low word bits not one");
	a_sclk_quiet: assert property (cs_n |-> !serial_clock_in)
		else $error("clock moves outside frame");
	a_cs_fall_steady: assert property ($fell(cs_n) |-> !serial_clock_in [*2])
		else $error("select fell with clock rising");
	a_frame_ends: assert property ($fell(cs_n) |-> ##[1:1000] cs_n)
		else $error("frame never closed");
	a_host_in_frame: assert property (host_sio_oe |-> !cs_n)
		else $error("host drives outside frame");

	// main scenarios reached
	c_receive: cover property ($rose(host_sio_oe));
	c_long_frame: cover property (!cs_n && falls_now == 7'h30);
	c_short_read: cover property ($rose(cs_n) && fall_cnt_reg == 7'h10);
endmodule : tsp_link_chk
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import tsp_pkg::*;
	logic        clk_sys, reset, req, wr_en, id_seq;
	logic [7:0]  wr_cmd;
	logic [13:0] temp_in;
	logic        conv_busy, result_valid, shutdown_active, test_mode, busy, done;
	logic [15:0] rd_temp, rd_id;
	int          miscompares, n_compared;
	// converter sample beside expected word
	logic [29:0] rows [8] = '{{14'h12C0, 16'h4B03}, {14'h0FA0, 16'h3E83}, {14'h0320, 16'h0C83},
		{14'h0001, 16'h0007}, {14'h0000, 16'h0003}, {14'h3FFF, 16'hFFFF}, {14'h3CE0, 16'hF383},
		{14'h3B00, 16'hEC03}};

	tsp_link_if link_if ();
	// short conversion and resume counts keep the run brief
	tsp_sensor_end #(.CONV_CYCLES(20)) tsp_sensor_end_inst (.clk_sys(clk_sys), .reset(reset),
		.link(link_if.dev), .temp_in(temp_in), .conv_busy(conv_busy), .result_valid(result_valid),
		.shutdown_active(shutdown_active), .test_mode(test_mode));
	tsp_host_end #(.RESUME_CYCLES(30)) tsp_host_end_inst (.clk_sys(clk_sys), .reset(reset),
		.link(link_if.host), .req(req), .wr_en(wr_en), .id_seq(id_seq), .wr_cmd(wr_cmd), .busy(busy),
		.done(done), .rd_temp(rd_temp), .rd_id(rd_id));
	tsp_link_chk tsp_link_chk_inst (.clk_sys(clk_sys), .reset(reset), .cs_n(link_if.cs_n),
		.serial_clock_in(link_if.serial_clock_in), .host_sio_out(link_if.host_sio_out),
		.host_sio_oe(link_if.host_sio_oe), .dev_sio_out(link_if.dev_sio_out),
		.dev_sio_oe(link_if.dev_sio_oe), .sio_level(link_if.sio_level));

	// ********
	// helpers
	// ********
	task automatic tally_and_finish();
		if (miscompares == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk16

	task automatic chk1(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask : chk1

	// outputs read 1 ns after the edge so its updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	task automatic frame(input logic we, input logic id, input logic [7:0] cmd);
		int k;
		@(posedge clk_sys);
		req <= 1'b1;
		wr_en <= we;
		id_seq <= id;
		wr_cmd <= cmd;
		@(posedge clk_sys);
		req <= 1'b0;
		#1;
		for (k = 0; k < 2000 && done !== 1'b1; k++) tick(1);
		if (k == 2000) begin
			chk1("done", 1'b1, done);
			tally_and_finish();
		end
		// the post-id wait must already be running when done pulses
		if (id) begin
			chk1("busy after id", 1'b1, busy);
		end
		// busy outlasts done after the id sequence
		for (k = 0; k < 200 && busy !== 1'b0; k++) tick(1);
		if (k == 200) begin
			chk1("busy", 1'b0, busy);
			tally_and_finish();
		end
	endtask : frame

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// ********
	// main sequence
	// ********
	initial begin
		reset = 1'b1;
		req = 1'b0;
		wr_en = 1'b0;
		id_seq = 1'b0;
		wr_cmd = 8'h00;
		temp_in = 14'h0320;
		miscompares = 0;
		n_compared = 0;
		tick(16);
		chk1("result_valid", 1'b0, result_valid);
		chk1("conv_busy", 1'b1, conv_busy);
		chk1("shutdown_active", 1'b0, shutdown_active);
		chk1("cs_n", 1'b1, link_if.cs_n);
		chk1("dev_sio_oe", 1'b0, link_if.dev_sio_oe);
		@(posedge clk_sys);
		reset <= 1'b0;
		// plain reads across the temperature range
		foreach (rows[i]) begin
			@(posedge clk_sys);
			temp_in <= rows[i][29:16];
			tick(60);
			frame(1'b0, 1'b0, 8'h00);
			chk16("rd_temp", rows[i][15:0], rd_temp);
			chk1("result_valid", 1'b1, result_valid);
		end
		// sample moves mid-read: word must hold until deselect
		@(posedge clk_sys);
		temp_in <= 14'h0001;
		tick(60);
		fork
			frame(1'b0, 1'b0, 8'h00);
			begin
				repeat (12) @(posedge clk_sys);
				temp_in <= 14'h3B00;
			end
		join
		chk16("rd_temp held", 16'h0007, rd_temp);
		tick(60);
		frame(1'b0, 1'b0, 8'h00);
		chk16("rd_temp refreshed", 16'hEC03, rd_temp);
		// shutdown and back
		frame(1'b1, 1'b0, CMD_SHUTDN);
		chk16("rd_temp full frame", 16'hEC03, rd_temp);
		tick(10);
		chk1("shutdown_active", 1'b1, shutdown_active);
		chk1("conv_busy", 1'b0, conv_busy);
		@(posedge clk_sys);
		temp_in <= 14'h0320;
		tick(60);
		frame(1'b0, 1'b0, 8'h00);
		chk16("rd_temp in shutdown", ID_WORD, rd_temp);
		frame(1'b1, 1'b0, CMD_CONVERT);
		tick(60);
		chk1("shutdown_active", 1'b0, shutdown_active);
		frame(1'b0, 1'b0, 8'h00);
		chk16("rd_temp resumed", 16'h0C83, rd_temp);
		// identification sequence in one long frame
		@(posedge clk_sys);
		temp_in <= 14'h3CE0;
		tick(60);
		frame(1'b0, 1'b1, 8'h00);
		chk16("rd_temp", 16'hF383, rd_temp);
		chk16("rd_id", ID_WORD, rd_id);
		chk1("shutdown_active", 1'b0, shutdown_active);
		// reset in mid-frame
		@(posedge clk_sys);
		req <= 1'b1;
		wr_en <= 1'b0;
		id_seq <= 1'b0;
		@(posedge clk_sys);
		req <= 1'b0;
		repeat (50) @(posedge clk_sys);
		reset <= 1'b1;
		tick(8);
		chk1("cs_n", 1'b1, link_if.cs_n);
		chk1("dev_sio_oe", 1'b0, link_if.dev_sio_oe);
		chk1("result_valid", 1'b0, result_valid);
		@(posedge clk_sys);
		reset <= 1'b0;
		tick(60);
		frame(1'b0, 1'b0, 8'h00);
		chk16("rd_temp after reset", 16'hF383, rd_temp);
		// an illegal code handed to the host must never reach the device
		frame(1'b1, 1'b0, 8'hA5);
		tick(10);
		chk16("rd_temp before bad code", 16'hF383, rd_temp);
		chk1("test_mode", 1'b0, test_mode);
		chk1("shutdown_active", 1'b0, shutdown_active);
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
